// ### design/fault_pkg.sv
// Constants and carriers for the processor fault recording unit.
// Assumes a 100 MHz processor clock and an APB register port.
package fault_pkg;
    localparam int CLK_MHZ = 100;
    localparam int ALIAS_EXTRA_CYC = 6;
    localparam logic [7:0] OFF_REASON = 8'h00;
    localparam logic [7:0] OFF_RET_PC = 8'h04;
    localparam logic [7:0] OFF_FVA    = 8'h08;
    localparam logic [7:0] OFF_PTE    = 8'h0c;
    localparam logic [7:0] OFF_WPTE   = 8'h10;
    localparam logic [7:0] OFF_TAG    = 8'h14;
    localparam logic [7:0] OFF_FRAME  = 8'h18;
    localparam logic [7:0] OFF_INDEX  = 8'h1c;
    localparam int DSLOT_BIT = 31;
    localparam int KIND_LSB  = 2;
    localparam int PROBE_MISS_BIT = 31;
    localparam logic [4:0] KIND_CLEAN_STORE = 5'h01;
    localparam logic [4:0] KIND_FETCH_BUS   = 5'h06;
    localparam logic [4:0] KIND_DATA_BUS    = 5'h07;
    localparam logic [4:0] KIND_OVERFLOW    = 5'h0c;
    localparam logic [31:0] PC_STEP = 32'h0000_0004;
    localparam logic VEC_EXC = 1'b0;
    localparam logic VEC_INT = 1'b1;
    localparam logic [31:0] PTE_BASE_MASK  = 32'hff80_0000;
    localparam logic [31:0] WPTE_BASE_MASK = 32'hf800_0000;
    localparam logic [31:0] TAG_MASK       = 32'hffff_e0ff;
    localparam logic [31:0] INDEX_MASK     = 32'h0000_003f;

    typedef enum logic [1:0] {
        REQ_BLOCK_READ = 2'b00,
        REQ_UPGRADE    = 2'b01,
        REQ_WORD_READ  = 2'b10
    } bus_req_t;

    typedef enum logic [2:0] {
        OP_ADD = 3'b000, OP_ADDI = 3'b001, OP_SUB = 3'b010,
        OP_DADD = 3'b011, OP_DADDI = 3'b100, OP_DSUB = 3'b101
    } alu_op_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] pc;
        logic        slot;
    } ctx_t;

    typedef struct packed {
        ctx_t        ctx;
        logic [31:0] va;
        logic        hit;
        logic        entry_valid;
        logic        dirty;
    } store_req_t;

    typedef struct packed {
        ctx_t        ctx;
        bus_req_t    kind;
        logic        err;
        logic        ack;
        logic        data_uerr;
        logic        fetch;
    } bus_resp_t;

    typedef struct packed {
        ctx_t        ctx;
        alu_op_t     op;
        logic [63:0] a;
        logic [63:0] b;
    } alu_req_t;

    typedef struct packed {
        logic       l1_miss;
        logic       l2_hit;
        logic [2:0] va_idx;
        logic [2:0] l2_pidx;
        logic       cacheable;
        logic       refill_done;
    } alias_in_t;

    typedef enum logic [1:0] {
        AL_IDLE    = 2'b00,
        AL_WAIT    = 2'b01,
        AL_RESOLVE = 2'b10
    } alias_state_t;
endpackage

// ### design/cpu_fault_exception_unit.sv
// Fault recording unit: clean-page stores, alias repair, bus errors, overflow.
// Assumes pipeline inputs synchronous to SYS_CLK_IN and an APB master.
// Function
// - Store hitting valid, clean TLB entry raises unmaskable clean-store exception.
// - Clean-store exception uses exception vector and records its kind code.
// - Faulting address goes to address, both pointer and tag staging registers.
// - Tag staging keeps active address space tag; frame staging left alone.
// - Return address is faulting pc, or preceding branch with slot flag set.
// - Probe loads index register with matching TLB slot number.
// - No coherency exception; alias handled by hardware line invalidation.
// - Alias repair costs exactly six cycles beyond the refill.
// - Alias is L1 miss, L2 hit, index mismatch, cacheable page.
// - Alias invalidates old index lines and rewrites stored primary index.
// - Error completion on block read, upgrade or word read raises bus error.
// - Ack on word read with uncorrectable data also raises bus error.
// - Bus errors use the interrupt vector.
// - Instruction fetch bus error records the fetch bus fault code.
// - Load or store bus error records the data bus fault code.
// - With slot flag set, faulting pc equals return address plus four.
// - Signed add, sub and 64-bit forms raise overflow on two's complement overflow.
// - Overflow uses exception vector and records overflow kind code.
// - Reason register holds kind field and the delay slot flag.
module cpu_fault_exception_unit
    import fault_pkg::*;
(
    input  wire logic        SYS_CLK_IN,
    input  wire logic        RST_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic [31:0]      PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    input  wire store_req_t  STORE_IN,
    input  wire bus_resp_t   BUS_RESP_IN,
    input  wire alu_req_t    ALU_IN,
    input  wire alias_in_t   ALIAS_IN,
    input  wire logic        PROBE_IN,
    input  wire logic        PROBE_HIT_IN,
    input  wire logic [5:0]  PROBE_SLOT_IN,
    output logic             EXC_TAKE_OUT,
    output logic             VECTOR_SEL_OUT,
    output logic [63:0]      ALU_RESULT_OUT,
    output logic             ALU_WB_EN_OUT,
    output logic             ALIAS_STALL_OUT,
    output logic             ALIAS_INVAL_OUT,
    output logic [2:0]       ALIAS_OLD_IDX_OUT,
    output logic             PIDX_WR_OUT,
    output logic [2:0]       PIDX_NEW_OUT
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [4:0]   exception_kind_field;
    logic         delay_slot_flag;
    logic [31:0]  return_pc_reg;
    logic [31:0]  faulting_va_reg;
    logic [31:0]  pte_pointer_reg;
    logic [31:0]  wide_pte_pointer_reg;
    logic [31:0]  tlb_tag_staging_reg;
    logic [31:0]  tlb_frame_staging_reg;
    logic [31:0]  index_reg;
    logic [7:0]   address_space_tag;

    assign address_space_tag = tlb_tag_staging_reg[7:0];

    // ------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------
    logic        clean_store;
    logic        bus_fault;
    logic        ovf;
    logic        is_wide;
    logic        is_sub;
    logic [63:0] b_eff;
    logic [63:0] sum;
    logic        take;
    logic        take_vec;
    logic [4:0]  take_kind;
    ctx_t        take_ctx;
    logic        wr;
    logic [31:0] rd_val;
    logic        rd_ok;

    assign clean_store = STORE_IN.ctx.valid && STORE_IN.hit
                         && STORE_IN.entry_valid && !STORE_IN.dirty;

    always_comb begin
        bus_fault = 1'b0;
        if (BUS_RESP_IN.ctx.valid && BUS_RESP_IN.err) begin
            bus_fault = 1'b1;
        end else if (BUS_RESP_IN.ctx.valid && BUS_RESP_IN.ack && BUS_RESP_IN.data_uerr
                     && BUS_RESP_IN.kind == REQ_WORD_READ) begin
            bus_fault = 1'b1;
        end
    end

    always_comb begin
        is_wide = (ALU_IN.op == OP_DADD) || (ALU_IN.op == OP_DADDI)
                  || (ALU_IN.op == OP_DSUB);
        is_sub = (ALU_IN.op == OP_SUB) || (ALU_IN.op == OP_DSUB);
        b_eff = is_sub ? ~ALU_IN.b : ALU_IN.b;
        sum = ALU_IN.a + b_eff + {63'h0, is_sub};
        if (is_wide) begin
            ovf = (ALU_IN.a[63] == b_eff[63]) && (sum[63] != ALU_IN.a[63]);
        end else begin
            ovf = (ALU_IN.a[31] == b_eff[31]) && (sum[31] != ALU_IN.a[31]);
        end
        ovf = ovf && ALU_IN.ctx.valid;
    end

    // Bus errors first, then clean stores, then overflow
    always_comb begin
        take = 1'b1;
        take_vec = VEC_EXC;
        take_kind = KIND_CLEAN_STORE;
        take_ctx = STORE_IN.ctx;
        if (bus_fault) begin
            take_vec = VEC_INT;
            take_ctx = BUS_RESP_IN.ctx;
            take_kind = BUS_RESP_IN.fetch ? KIND_FETCH_BUS : KIND_DATA_BUS;
        end else if (clean_store) begin
            take_kind = KIND_CLEAN_STORE;
        end else if (ovf) begin
            take_kind = KIND_OVERFLOW;
            take_ctx = ALU_IN.ctx;
        end else begin
            take = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            EXC_TAKE_OUT <= 1'b0;
            VECTOR_SEL_OUT <= VEC_EXC;
        end else begin
            EXC_TAKE_OUT <= take;
            if (take) begin
                VECTOR_SEL_OUT <= take_vec;
            end
        end
    end

    // ------------------------------------------------------------
    // Arithmetic result
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            ALU_RESULT_OUT <= 64'h0;
            ALU_WB_EN_OUT <= 1'b0;
        end else begin
            ALU_WB_EN_OUT <= ALU_IN.ctx.valid && !ovf && !take;
            if (ALU_IN.ctx.valid) begin
                ALU_RESULT_OUT <= is_wide ? sum : {{32{sum[31]}}, sum[31:0]};
            end
        end
    end

    // ------------------------------------------------------------
    // Exception state capture
    // ------------------------------------------------------------
    assign wr = PSEL_IN && PENABLE_IN && PWRITE_IN;

    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            exception_kind_field <= 5'h00;
            delay_slot_flag <= 1'b0;
            return_pc_reg <= 32'h0;
        end else begin
            if (wr && PADDR_IN == OFF_RET_PC) begin
                return_pc_reg <= PWDATA_IN;
            end
            if (take) begin
                exception_kind_field <= take_kind;
                delay_slot_flag <= take_ctx.slot;
                return_pc_reg <= take_ctx.slot ? take_ctx.pc - PC_STEP
                                               : take_ctx.pc;
            end
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            faulting_va_reg <= 32'h0;
            pte_pointer_reg <= 32'h0;
            wide_pte_pointer_reg <= 32'h0;
            tlb_tag_staging_reg <= 32'h0;
            tlb_frame_staging_reg <= 32'h0;
        end else begin
            if (wr && PADDR_IN == OFF_PTE) begin
                pte_pointer_reg <= PWDATA_IN & PTE_BASE_MASK;
            end
            if (wr && PADDR_IN == OFF_WPTE) begin
                wide_pte_pointer_reg <= PWDATA_IN & WPTE_BASE_MASK;
            end
            if (wr && PADDR_IN == OFF_TAG) begin
                tlb_tag_staging_reg <= PWDATA_IN & TAG_MASK;
            end
            if (wr && PADDR_IN == OFF_FRAME) begin
                tlb_frame_staging_reg <= PWDATA_IN;
            end
            if (take && !bus_fault && clean_store) begin
                faulting_va_reg <= STORE_IN.va;
                pte_pointer_reg <= {pte_pointer_reg[31:23], STORE_IN.va[31:13], 4'h0};
                wide_pte_pointer_reg <= {wide_pte_pointer_reg[31:27], 4'h0,
                                         STORE_IN.va[31:13], 4'h0};
                tlb_tag_staging_reg <= {STORE_IN.va[31:13], 5'h00,
                                        address_space_tag};
            end
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            index_reg <= 32'h0;
        end else if (PROBE_IN) begin
            index_reg <= PROBE_HIT_IN ? {26'h0, PROBE_SLOT_IN}
                                      : (32'h1 << PROBE_MISS_BIT);
        end else if (wr && PADDR_IN == OFF_INDEX) begin
            index_reg <= PWDATA_IN & INDEX_MASK;
        end
    end

    // ------------------------------------------------------------
    // Alias repair
    // ------------------------------------------------------------
    alias_state_t al_state;
    logic [2:0]   al_cnt;
    logic         alias_hit;

    assign alias_hit = ALIAS_IN.l1_miss && ALIAS_IN.l2_hit && ALIAS_IN.cacheable
                       && (ALIAS_IN.va_idx != ALIAS_IN.l2_pidx);
    assign ALIAS_STALL_OUT = (al_state == AL_RESOLVE);

    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            al_state <= AL_IDLE;
            al_cnt <= 3'h0;
            ALIAS_INVAL_OUT <= 1'b0;
            PIDX_WR_OUT <= 1'b0;
            ALIAS_OLD_IDX_OUT <= 3'h0;
            PIDX_NEW_OUT <= 3'h0;
        end else begin
            ALIAS_INVAL_OUT <= 1'b0;
            PIDX_WR_OUT <= 1'b0;
            case (al_state)
                AL_IDLE: begin
                    if (alias_hit) begin
                        ALIAS_OLD_IDX_OUT <= ALIAS_IN.l2_pidx;
                        PIDX_NEW_OUT <= ALIAS_IN.va_idx;
                        al_state <= AL_WAIT;
                    end
                end
                AL_WAIT: begin
                    if (ALIAS_IN.refill_done) begin
                        al_cnt <= 3'(ALIAS_EXTRA_CYC - 1);
                        ALIAS_INVAL_OUT <= 1'b1;
                        PIDX_WR_OUT <= 1'b1;
                        al_state <= AL_RESOLVE;
                    end
                end
                AL_RESOLVE: begin
                    if (al_cnt == 3'h0) begin
                        al_state <= AL_IDLE;
                    end else begin
                        al_cnt <= al_cnt - 3'h1;
                    end
                end
                default: begin
                    al_state <= AL_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    always_comb begin
        rd_ok = 1'b1;
        rd_val = 32'h0;
        if (PADDR_IN == OFF_REASON) begin
            rd_val = ({31'h0, delay_slot_flag} << DSLOT_BIT)
                     | ({27'h0, exception_kind_field} << KIND_LSB);
        end else if (PADDR_IN == OFF_RET_PC) begin
            rd_val = return_pc_reg;
        end else if (PADDR_IN == OFF_FVA) begin
            rd_val = faulting_va_reg;
        end else if (PADDR_IN == OFF_PTE) begin
            rd_val = pte_pointer_reg;
        end else if (PADDR_IN == OFF_WPTE) begin
            rd_val = wide_pte_pointer_reg;
        end else if (PADDR_IN == OFF_TAG) begin
            rd_val = tlb_tag_staging_reg;
        end else if (PADDR_IN == OFF_FRAME) begin
            rd_val = tlb_frame_staging_reg;
        end else if (PADDR_IN == OFF_INDEX) begin
            rd_val = index_reg;
        end else begin
            rd_ok = 1'b0;
        end
    end

    assign PREADY_OUT = 1'b1;

    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            PRDATA_OUT <= 32'h0;
            PSLVERR_OUT <= 1'b0;
        end else if (PSEL_IN && !PENABLE_IN) begin
            PRDATA_OUT <= PWRITE_IN ? 32'h0 : rd_val;
            PSLVERR_OUT <= !rd_ok;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_refill_in_wait;
        al_state == AL_WAIT && ALIAS_IN.refill_done;
    endsequence

    sequence s_six_stall;
        ALIAS_STALL_OUT [*6] ##1 !ALIAS_STALL_OUT;
    endsequence

    AST_CLEAN_STORE: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        clean_store && !bus_fault |=> EXC_TAKE_OUT && VECTOR_SEL_OUT == VEC_EXC
            && exception_kind_field == KIND_CLEAN_STORE)
        else $error("clean store not taken");

    AST_VA_CAPTURE: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        clean_store && !bus_fault |=> faulting_va_reg == $past(STORE_IN.va)
            && tlb_tag_staging_reg[31:13] == faulting_va_reg[31:13]
            && pte_pointer_reg[22:4] == faulting_va_reg[31:13])
        else $error("fault address not captured");

    AST_ADDRESS_SPACE_TAG_KEEP: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        take && !wr |=> $stable(address_space_tag)
            && $stable(tlb_frame_staging_reg))
        else $error("space tag or frame changed");

    AST_RETURN_PC: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        take && take_ctx.slot |=> delay_slot_flag
            && return_pc_reg + PC_STEP == $past(take_ctx.pc))
        else $error("slot return address wrong");

    AST_NO_SLOT: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        take && !take_ctx.slot |=> !delay_slot_flag
            && return_pc_reg == $past(take_ctx.pc))
        else $error("slot flag not cleared");

    AST_PROBE: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        PROBE_IN && PROBE_HIT_IN |=> index_reg[5:0] == $past(PROBE_SLOT_IN)
            && !index_reg[PROBE_MISS_BIT])
        else $error("probe index wrong");

    AST_ALIAS_STALL: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        s_refill_in_wait |=> s_six_stall)
        else $error("alias stall not six cycles");

    AST_ALIAS_FIX: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        al_state == AL_IDLE && alias_hit ##1 s_refill_in_wait |=> ALIAS_INVAL_OUT
            && PIDX_WR_OUT && PIDX_NEW_OUT == $past(ALIAS_IN.va_idx, 2))
        else $error("alias repair missing");

    AST_BUS_VEC: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        bus_fault |=> EXC_TAKE_OUT && VECTOR_SEL_OUT == VEC_INT)
        else $error("bus error vector wrong");

    AST_BUS_KIND: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        bus_fault |=> exception_kind_field
            == ($past(BUS_RESP_IN.fetch) ? KIND_FETCH_BUS : KIND_DATA_BUS))
        else $error("bus fault code wrong");

    AST_OVERFLOW: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        ovf && !bus_fault && !clean_store |=> !ALU_WB_EN_OUT
            && exception_kind_field == KIND_OVERFLOW && VECTOR_SEL_OUT == VEC_EXC)
        else $error("overflow handling wrong");

endmodule // cpu_fault_exception_unit

// ### sim/bus_agent.sv
// Behavioural external bus agent that answers processor read requests.
// Assumes a request pulse with fields held until busy_out falls.
module bus_agent
    import fault_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       req_in,
    input  wire bus_req_t   kind_in,
    input  wire logic [1:0] mode_in,
    input  wire logic       fetch_in,
    input  wire ctx_t       ctx_in,
    input  wire logic [2:0] delay_in,
    output bus_resp_t       resp_out,
    output logic            busy_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Completion response, prompt or delayed
    // ----------------------------------------
    bus_resp_t  nxt;
    logic [2:0] wait_cnt = 3'h0;
    initial resp_out = '0;
    initial busy_out = 1'b0;
    always @(posedge clk_in) begin
        nxt = bus_resp_t'(~resp_out);
        nxt.ctx.valid = 1'b0;
        if (busy_out && wait_cnt == 3'h0) begin
            nxt.ctx = ctx_in;
            nxt.kind = kind_in;
            nxt.fetch = fetch_in;
            nxt.err = (mode_in == 2'd1);
            nxt.ack = (mode_in != 2'd1);
            nxt.data_uerr = (mode_in == 2'd2);
        end
        resp_out <= nxt;
        if (busy_out && wait_cnt == 3'h0)
            busy_out <= 1'b0;
        else if (busy_out)
            wait_cnt <= wait_cnt - 3'h1;
        else if (req_in) begin
            busy_out <= 1'b1;
            wait_cnt <= delay_in;
        end
    end
endmodule // bus_agent

// ### sim/testbench.sv
// Self-checking bench for the fault recording unit.
// Assumes fault_pkg, the design top and bus_agent are compiled first.
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module testbench import fault_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, prdata, address_space_tag_word, frame;
    logic        pready, pslverr, exc, vsel, wb, stall, inval, pwr, probe = 0, phit = 0;
    logic [5:0]  pslot = '0;
    logic [63:0] result, rv;
    logic [2:0]  old_idx, new_idx, bdelay = '0;
    logic [1:0]  bmode = '0;
    logic        breq = 0, bfetch = 0, bbusy, vv;
    store_req_t  st = '0;
    alu_req_t    alu = '0;
    alias_in_t   al = '0;
    bus_resp_t   resp;
    bus_req_t    bkind = REQ_BLOCK_READ;
    ctx_t        bctx = '0;
    logic        vq[$];
    logic [63:0] rq[$];
    int          num_errors = 0, n_tests = 0, cyc = 0;

    cpu_fault_exception_unit i_cpu_fault_exception_unit (
        .SYS_CLK_IN(sys_clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .STORE_IN(st), .BUS_RESP_IN(resp),
        .ALU_IN(alu), .ALIAS_IN(al), .PROBE_IN(probe), .PROBE_HIT_IN(phit),
        .PROBE_SLOT_IN(pslot), .EXC_TAKE_OUT(exc), .VECTOR_SEL_OUT(vsel),
        .ALU_RESULT_OUT(result), .ALU_WB_EN_OUT(wb), .ALIAS_STALL_OUT(stall),
        .ALIAS_INVAL_OUT(inval), .ALIAS_OLD_IDX_OUT(old_idx), .PIDX_WR_OUT(pwr),
        .PIDX_NEW_OUT(new_idx));
    bus_agent i_bus_agent (.clk_in(sys_clk), .req_in(breq), .kind_in(bkind),
        .mode_in(bmode), .fetch_in(bfetch), .ctx_in(bctx), .delay_in(bdelay),
        .resp_out(resp), .busy_out(bbusy));

    always #5 sys_clk = ~sys_clk;
    // ----------------------------------------
    // Verdict, timeout and output watcher
    // ----------------------------------------
    task automatic complete_run();
        $display("errors=%0d checks=%0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            complete_run();
        end
    end
    always @(posedge sys_clk) begin
        if (!rst && exc === 1'b1) begin
            `CHK(vq.size() > 0, 1'b1)
            if (vq.size() > 0) begin
                vv = vq.pop_front();
                `CHK(vsel, vv)
            end
        end
        if (!rst && wb === 1'b1) begin
            `CHK(rq.size() > 0, 1'b1)
            if (rq.size() > 0) begin
                rv = rq.pop_front();
                `CHK(result, rv)
            end
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk_rec(logic [4:0] kind, logic [31:0] pc, logic s);
        logic [31:0] r;
        logic e;
        for (int i = 0; i < 20 && vq.size() > 0; i++) @(posedge sys_clk);
        apb(1'b0, OFF_REASON, '0, r, e);
        `CHK(r[KIND_LSB+:5], kind)
        `CHK(r[DSLOT_BIT], s)
        apb(1'b0, OFF_RET_PC, '0, r, e);
        `CHK(r + (s ? PC_STEP : 32'h0), pc)
    endtask
    task automatic store(logic h, logic ev, logic d);
        logic [31:0] va, pc, r;
        logic s, e;
        va = $urandom;
        pc = $urandom & 32'hffff_fffc;
        s = 1'($urandom);
        if (h && ev && !d) vq.push_back(VEC_EXC);
        @(posedge sys_clk);
        st <= '{ctx: '{valid: 1'b1, pc: pc, slot: s}, va: va, hit: h, entry_valid: ev, dirty: d};
        @(posedge sys_clk);
        st.ctx.valid <= 1'b0;
        if (h && ev && !d) begin
            chk_rec(KIND_CLEAN_STORE, pc, s);
            apb(1'b0, OFF_FVA, '0, r, e);
            `CHK(r, va)
            apb(1'b0, OFF_PTE, '0, r, e);
            `CHK(r[22:4], va[31:13])
            apb(1'b0, OFF_WPTE, '0, r, e);
            `CHK(r[22:4], va[31:13])
            apb(1'b0, OFF_TAG, '0, r, e);
            `CHK({r[31:13], r[7:0]}, {va[31:13], address_space_tag_word[7:0]})
            apb(1'b0, OFF_FRAME, '0, r, e);
            `CHK(r, frame)
        end
    endtask
    task automatic bus(bus_req_t k, logic [1:0] m);
        logic [31:0] pc;
        logic f, s, hit;
        pc = $urandom & 32'hffff_fffc;
        f = 1'($urandom);
        s = 1'($urandom);
        hit = (m == 2'd1) || (m == 2'd2 && k == REQ_WORD_READ);
        if (hit) vq.push_back(VEC_INT);
        @(posedge sys_clk);
        breq <= 1'b1;
        bkind <= k;
        bmode <= m;
        bfetch <= f;
        bdelay <= 3'($urandom);
        bctx <= '{valid: 1'b1, pc: pc, slot: s};
        @(posedge sys_clk);
        breq <= 1'b0;
        do @(posedge sys_clk); while (bbusy === 1'b1);
        if (hit) chk_rec(f ? KIND_FETCH_BUS : KIND_DATA_BUS, pc, s);
    endtask
    task automatic arith(alu_op_t op, logic big);
        logic [64:0] t;
        logic [63:0] a, b;
        logic [31:0] pc;
        logic w, sub, ov, s;
        w = op inside {OP_DADD, OP_DADDI, OP_DSUB};
        sub = op inside {OP_SUB, OP_DSUB};
        pc = $urandom & 32'hffff_fffc;
        s = 1'($urandom);
        a = big ? (w ? 64'h7fff_ffff_ffff_ffff : 64'h7fff_ffff) : 64'($signed(16'($urandom)));
        b = big ? (sub ? '1 : 64'h1) : 64'($signed(16'($urandom)));
        if (w) begin
            t = sub ? {a[63], a} - {b[63], b} : {a[63], a} + {b[63], b};
            ov = t[64] ^ t[63];
        end else begin
            t = sub ? {a[31], a[31:0]} - {b[31], b[31:0]} : {a[31], a[31:0]} + {b[31], b[31:0]};
            ov = t[32] ^ t[31];
            t[63:32] = {32{t[31]}};
        end
        if (ov) vq.push_back(VEC_EXC);
        else rq.push_back(t[63:0]);
        @(posedge sys_clk);
        alu <= '{ctx: '{valid: 1'b1, pc: pc, slot: s}, op: op, a: a, b: b};
        @(posedge sys_clk);
        alu.ctx.valid <= 1'b0;
        if (ov) chk_rec(KIND_OVERFLOW, pc, s);
    endtask
    task automatic probe_run(logic h);
        logic [31:0] r;
        logic [5:0] sl;
        logic e;
        sl = 6'($urandom);
        @(posedge sys_clk);
        probe <= 1'b1;
        phit <= h;
        pslot <= sl;
        @(posedge sys_clk);
        probe <= 1'b0;
        apb(1'b0, OFF_INDEX, '0, r, e);
        if (h) `CHK(r[5:0], sl)
        else `CHK(r[PROBE_MISS_BIT], 1'b1)
    endtask
    task automatic alias_run(logic cach, logic same);
        logic [2:0] vi, pi;
        int n, seen;
        vi = 3'($urandom);
        pi = same ? vi : vi ^ (3'($urandom % 7) + 3'h1);
        n = 0;
        seen = 0;
        @(posedge sys_clk);
        al <= '{l1_miss: 1, l2_hit: 1, va_idx: vi, l2_pidx: pi, cacheable: cach, refill_done: 0};
        @(posedge sys_clk);
        al <= '{refill_done: cach, default: '0};
        if (!cach) begin
            repeat ($urandom % 4 + 1) @(posedge sys_clk);
            al.refill_done <= 1'b1;
        end
        @(posedge sys_clk);
        al.refill_done <= 1'b0;
        repeat (12) begin
            @(posedge sys_clk);
            n += (stall === 1'b1);
            if (inval === 1'b1) begin
                seen++;
                `CHK({old_idx, pwr, new_idx}, {pi, 1'b1, vi})
            end
        end
        `CHK(n, (cach && !same) ? 6 : 0)
        `CHK(seen, (cach && !same) ? 1 : 0)
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] r;
        logic e;
        void'($urandom(32'ha571));
        address_space_tag_word = $urandom & 32'h0000_00ff;
        frame = $urandom;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        apb(1'b0, 8'h20, '0, r, e);
        `CHK({e, r}, {1'b1, 32'h0})
        apb(1'b1, OFF_TAG, address_space_tag_word, r, e);
        apb(1'b1, OFF_FRAME, frame, r, e);
        store(1, 1, 0);
        store(1, 1, 1);
        store(1, 0, 0);
        store(0, 1, 0);
        store(1, 1, 0);
        for (int k = 0; k < 6; k++)
            for (int m = 0; m < 3; m++)
                bus(bus_req_t'(k % 3), 2'(m));
        for (int k = 0; k < 6; k++) begin
            arith(alu_op_t'(k), 1'b0);
            arith(alu_op_t'(k), 1'b1);
        end
        probe_run(1'b1);
        probe_run(1'b0);
        alias_run(1'b1, 1'b0);
        alias_run(1'b0, 1'b0);
        alias_run(1'b1, 1'b1);
        alias_run(1'b1, 1'b0);
        repeat (4) @(posedge sys_clk);
        `CHK(vq.size() + rq.size(), 0)
        complete_run();
    end
endmodule // testbench
